// [logic/be_source.sv]
// User-device end of the best-effort packet read service: a request count
// area and a packet data area, both answered to an RMAP target engine.
// Assumes the RMAP target and the packet producer run on core_clk.
`timescale 1ns/1ps
`include "be_source_defs.svh"
module be_source (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic [`LEN_W-1:0]        cfg_read_size,
  input  wire logic                     wr_valid,
  input  wire be_source_pkg::wr_beat_type wr_beat,
  output      logic                     wr_ready,
  input  wire logic                     post,
  input  wire logic                     req_valid,
  input  wire be_source_pkg::rd_req_type  req,
  output      logic                     req_ready,
  output      logic                     rsp_start,
  output      logic [`LEN_W-1:0]        rsp_len,
  output      logic                     rsp_valid,
  output      be_source_pkg::rd_beat_type rsp_beat,
  input  wire logic                     rsp_ready,
  output      logic [`CNT_W-1:0]        pending_count
);
  import be_source_pkg::*;

  logic [7:0]        mem_ff [`DATA_BYTES];
  logic [`LEN_W-1:0] slot_len_ff [`NUM_SLOTS];
  logic [`SLOT_W-1:0] wr_slot_ff, rd_slot_ff, cur_slot_ff;
  logic [`BYTE_W:0]  wr_byte_ff;
  logic [`CNT_W-1:0] pending_ff, staged_ff, occupancy;
  logic [`LEN_W-1:0] len_ff, idx_ff, nxt_len;
  logic              area_ff;
  rd_state_type      state_ff;

  logic wr_take, wr_done, rd_take, data_take, sent_last;

  // Slot 16 bytes, area 64 bytes: four slots, a packet keeps at most one slot
  assign occupancy = pending_ff + staged_ff + {3'b000, state_ff != ST_IDLE && area_ff == `AREA_DATA};
  assign wr_ready  = occupancy < `CNT_W'(`NUM_SLOTS);
  assign wr_take   = wr_valid && wr_ready;
  assign wr_done   = wr_take && wr_beat.last;
  assign req_ready = state_ff == ST_IDLE;
  assign rd_take   = req_valid && req_ready;
  assign data_take = rd_take && req.area == `AREA_DATA;
  assign sent_last = state_ff == ST_SEND && rsp_ready && idx_ff + 8'h01 == len_ff;
  assign pending_count = pending_ff;

  function automatic logic [`LEN_W-1:0] min_len(input logic [`LEN_W-1:0] a, input logic [`LEN_W-1:0] b);
    min_len = (a < b) ? a : b;
  endfunction

  // Data reply length never above request, configured size or packet; count reply never above request or COUNT_BYTES
  always_comb begin
    if (req.area == `AREA_COUNT) begin
      nxt_len = min_len(req.len, `COUNT_BYTES);
    end else if (pending_ff == '0) begin
      nxt_len = '0;
    end else begin
      nxt_len = min_len(min_len(req.len, cfg_read_size), slot_len_ff[rd_slot_ff]);
    end
  end

  // Packet producer fills the slot; excess bytes beyond a slot are dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_byte_ff <= '0;
      wr_slot_ff <= '0;
    end else if (wr_take) begin
      wr_byte_ff <= wr_beat.last ? '0 : (wr_byte_ff == (`BYTE_W+1)'(`SLOT_BYTES) ? wr_byte_ff : wr_byte_ff + 1'b1);
      if (wr_beat.last) begin
        wr_slot_ff <= wr_slot_ff + 1'b1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DATA_BYTES; g++) begin : g_mem
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          mem_ff[g] <= 8'h00;
        end else if (wr_take && !wr_byte_ff[`BYTE_W] && {wr_slot_ff, wr_byte_ff[`BYTE_W-1:0]} == g) begin
          mem_ff[g] <= wr_beat.data;
        end
      end
    end
    for (g = 0; g < `NUM_SLOTS; g++) begin : g_len
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          slot_len_ff[g] <= '0;
        end else if (wr_done && wr_slot_ff == g) begin
          slot_len_ff[g] <= wr_byte_ff[`BYTE_W] ? `SLOT_BYTES_L : `LEN_W'(wr_byte_ff) + 8'h01;
        end
      end
    end
  endgenerate

  // Count becomes visible only after the data is complete in its slot
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      staged_ff <= '0;
    end else begin
      staged_ff <= (post ? '0 : staged_ff) + {3'b000, wr_done};
    end
  end

  // Published count; post and data access in one cycle both count
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_ff <= '0;
    end else begin
      pending_ff <= pending_ff + (post ? staged_ff : '0) - {3'b000, data_take && pending_ff != '0};
    end
  end

  // Next packet is staged at the access so a back-to-back read sees it
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_slot_ff  <= '0;
      cur_slot_ff <= '0;
    end else if (data_take && pending_ff != '0) begin
      cur_slot_ff <= rd_slot_ff;
      rd_slot_ff  <= rd_slot_ff + 1'b1;
    end
  end

  // Reply sequencer: header with true length, then the bytes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      len_ff   <= '0;
      idx_ff   <= '0;
      area_ff  <= `AREA_COUNT;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (rd_take) begin
            state_ff <= ST_HEAD;
            len_ff   <= nxt_len;
            idx_ff   <= '0;
            area_ff  <= req.area;
          end
        end
        ST_HEAD: begin
          state_ff <= (len_ff == '0) ? ST_IDLE : ST_SEND;
        end
        ST_SEND: begin
          if (rsp_ready) begin
            idx_ff <= idx_ff + 8'h01;
          end
          if (sent_last) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign rsp_start = state_ff == ST_HEAD;
  assign rsp_len   = len_ff;
  assign rsp_valid = state_ff == ST_SEND;

  // Count read is big-endian; the count fits in the lowest byte
  always_comb begin
    rsp_beat.last = idx_ff + 8'h01 == len_ff;
    if (area_ff == `AREA_COUNT) begin
      rsp_beat.data = (idx_ff == 8'h03) ? {4'h0, pending_ff} : 8'h00;
    end else begin
      rsp_beat.data = mem_ff[{cur_slot_ff, idx_ff[`BYTE_W-1:0]}];
    end
  end

  a_len_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
    rsp_start |-> rsp_len <= `SLOT_BYTES_L && (area_ff == `AREA_COUNT || rsp_len <= cfg_read_size))
    else $error("reply longer than allowed");

  a_cfg_honour: assert property (@(posedge core_clk) disable iff (!rst_b)
    data_take && pending_ff != '0 && slot_len_ff[rd_slot_ff] >= cfg_read_size && req.len >= cfg_read_size
    |=> rsp_len == $past(cfg_read_size))
    else $error("configured read size not used");

  a_dec_access: assert property (@(posedge core_clk) disable iff (!rst_b)
    data_take && pending_ff != '0 && !post |=> pending_ff == $past(pending_ff) - 1'b1)
    else $error("count not decremented on data access");

  a_post_only: assert property (@(posedge core_clk) disable iff (!rst_b)
    !post && !data_take |=> $stable(pending_ff))
    else $error("count changed without post or access");

  a_empty_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    data_take && pending_ff == '0 |=> rsp_start && rsp_len == 8'h00 ##1 !rsp_valid)
    else $error("empty data access returned bytes");

  a_beat_count: assert property (@(posedge core_clk) disable iff (!rst_b)
    (rsp_start && rsp_len != '0) || (rsp_valid && !(rsp_ready && rsp_beat.last)) |=> rsp_valid)
    else $error("reply ended before its length");

  a_count_reply: assert property (@(posedge core_clk) disable iff (!rst_b)
    rd_take && req.area == `AREA_COUNT && req.len >= `COUNT_BYTES |=> rsp_start && rsp_len == `COUNT_BYTES)
    else $error("count reply not four bytes");

  a_area_room: assert property (@(posedge core_clk) disable iff (!rst_b)
    occupancy <= `CNT_W'(`NUM_SLOTS) && (!rsp_start || rsp_len < 8'(`DATA_BYTES)))
    else $error("data area overrun");

  a_slot_kept: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_take |-> !(state_ff != ST_IDLE && area_ff == `AREA_DATA && len_ff != '0 && wr_slot_ff == cur_slot_ff))
    else $error("slot under read overwritten");
endmodule // be_source

// [logic/be_source_defs.svh]
// Constants of the best-effort packet source: area codes, sizes and widths.
// Included by the package and the design file of the block.
`ifndef BE_SOURCE_DEFS_SVH
`define BE_SOURCE_DEFS_SVH
`define AREA_COUNT   1'b0
`define AREA_DATA    1'b1
`define NUM_SLOTS    4
`define SLOT_W       2
`define SLOT_BYTES   16
`define BYTE_W       4
`define LEN_W        8
`define CNT_W        4
`define COUNT_BYTES  8'h04
`define SLOT_BYTES_L 8'h10
`define DATA_BYTES   (`NUM_SLOTS * `SLOT_BYTES)
`endif

// [logic/be_source_pkg.sv]
// Types of the best-effort packet source.
// Assumes the constants header is on the include path.
`include "be_source_defs.svh"
package be_source_pkg;
  typedef struct packed {
    logic              area;
    logic [`LEN_W-1:0] len;
  } rd_req_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rd_beat_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } wr_beat_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_SEND = 2'b11
  } rd_state_type;
endpackage

// [testbench/be_master.sv]
// Polling master model facing the best-effort packet source.
// Assumes the source answers on core_clk; the bench calls its tasks.
`timescale 1ns/1ps
module be_master
  import be_source_pkg::*;
(
  input  wire logic        core_clk,
  output      logic        req_valid,
  output      rd_req_type  req,
  input  wire logic        req_ready,
  input  wire logic        rsp_start,
  input  wire logic [7:0]  rsp_len,
  input  wire logic        rsp_valid,
  input  wire rd_beat_type rsp_beat,
  output      logic        rsp_ready,
  input  wire logic        slow
);
  logic [7:0] got[$];
  logic [7:0] got_len;
  logic [3:0] dev_cnt;
  int         last_bad;
  initial begin
    req_valid = 1'b0;
    req = '0;
    rsp_ready = 1'b1;
    dev_cnt = 4'h0;
  end
  always @(posedge core_clk) rsp_ready <= slow ? ~rsp_ready : 1'b1;
  task automatic xfer(input logic area, input logic [7:0] len);
    int n;
    got = {};
    got_len = 8'h00;
    req_valid <= 1'b1;
    req <= '{area: area, len: len};
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // Released request shows garbage, not the last value
    req <= '{area: ~area, len: ~len};
    n = 0;
    while (rsp_start !== 1'b1 && n < 8) begin
      @(posedge core_clk);
      n++;
    end
    // A lost reply is never reissued
    if (n == 8) return;
    got_len = rsp_len;
    while (got.size() < got_len && n < 200) begin
      @(posedge core_clk);
      n++;
      if (rsp_valid && rsp_ready) begin
        got.push_back(rsp_beat.data);
        // End marker must sit on the final byte only
        if (rsp_beat.last !== (got.size() == got_len)) last_bad++;
      end
    end
  endtask
  task automatic poll();
    xfer(1'b0, 8'h04);
    if (got.size() == 4) dev_cnt = got[3][3:0];
  endtask
  task automatic collect(input logic [7:0] len);
    xfer(1'b1, len);
    // Idle gap so the target sees spaced read commands
    @(posedge core_clk);
    dev_cnt = (dev_cnt == 4'h0) ? 4'h0 : dev_cnt - 4'h1;
  endtask
endmodule // be_master

// [testbench/be_source_tb_top.sv]
// Self-checking bench for the best-effort packet source.
// Assumes the package and the master model are compiled first.
`timescale 1ns/1ps
`include "be_source_defs.svh"
module be_source_tb_top;
  import be_source_pkg::*;
  logic        core_clk, rst_b, wr_valid, wr_ready, post, slow;
  logic        req_valid, req_ready, rsp_start, rsp_valid, rsp_ready;
  logic [7:0]  cfg_read_size, rsp_len;
  logic [3:0]  pending_count;
  wr_beat_type wr_beat;
  rd_req_type  req;
  rd_beat_type rsp_beat;
  int          bad_count, num_checks, cyc;
  be_source be_source_i(.core_clk(core_clk), .rst_b(rst_b), .cfg_read_size(cfg_read_size),
    .wr_valid(wr_valid), .wr_beat(wr_beat), .wr_ready(wr_ready), .post(post), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_start(rsp_start), .rsp_len(rsp_len), .rsp_valid(rsp_valid),
    .rsp_beat(rsp_beat), .rsp_ready(rsp_ready), .pending_count(pending_count));
  be_master be_master_i(.core_clk(core_clk), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_start(rsp_start), .rsp_len(rsp_len), .rsp_valid(rsp_valid), .rsp_beat(rsp_beat),
    .rsp_ready(rsp_ready), .slow(slow));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      wr_valid <= 1'b1;
      wr_beat <= '{data: base + 8'(i), last: i == n - 1};
      do @(posedge core_clk); while (wr_ready !== 1'b1);
    end
    wr_valid <= 1'b0;
    wr_beat <= '{data: ~base, last: 1'b0};
    @(posedge core_clk);
  endtask
  task automatic pub();
    post <= 1'b1;
    @(posedge core_clk);
    post <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] len, input logic [7:0] exp_len, input logic [7:0] base);
    be_master_i.collect(len);
    chk(be_master_i.got_len, exp_len);
    for (int i = 0; i < exp_len; i++) chk(be_master_i.got[i], base + 8'(i));
    chk(8'(be_master_i.last_bad), 8'h00);
  endtask
  task automatic t_empty();
    be_master_i.poll();
    chk(be_master_i.got_len, 8'h04);
    chk(be_master_i.got[3], 8'h00);
    rd(8'h10, 8'h00, 8'h00);
    chk({4'h0, pending_count}, 8'h00);
    $display("t_empty done");
  endtask
  task automatic t_order();
    push(5, 8'h10);
    push(16, 8'h20);
    be_master_i.poll();
    chk(be_master_i.got[3], 8'h00);
    pub();
    chk({4'h0, pending_count}, 8'h02);
    be_master_i.poll();
    chk(be_master_i.got[3], 8'h02);
    rd(8'h10, 8'h05, 8'h10);
    chk({4'h0, pending_count}, 8'h01);
    rd(8'h10, 8'h10, 8'h20);
    chk({4'h0, pending_count}, 8'h00);
    $display("t_order done");
  endtask
  task automatic t_cfg();
    cfg_read_size <= 8'h08;
    slow <= 1'b1;
    push(12, 8'h40);
    pub();
    rd(8'h10, 8'h08, 8'h40);
    slow <= 1'b0;
    cfg_read_size <= 8'h10;
    $display("t_cfg done");
  endtask
  task automatic t_full();
    for (int i = 0; i < 4; i++) push(1, 8'h60 + 8'(i));
    chk({7'h0, wr_ready}, 8'h00);
    pub();
    chk({4'h0, pending_count}, 8'h04);
    for (int i = 0; i < 4; i++) rd(8'h10, 8'h01, 8'h60 + 8'(i));
    chk({7'h0, wr_ready}, 8'h01);
    $display("t_full done");
  endtask
  initial begin
    rst_b = 1'b0;
    cfg_read_size = 8'h10;
    wr_valid = 1'b0;
    wr_beat = '0;
    post = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_empty();
    t_order();
    t_cfg();
    t_full();
    test_done();
  end
endmodule // be_source_tb_top
